// File: pkg/sac_regs.svh
// constants of the converter control block
// Overview of operation
// - converter clock is cpu clock divided by 16, 8, 1 or 2 per select
// - sampling window lasts 1, 2, 4 or 8 converter clocks per select
// - resolution 8 bits for 00, 10 bits for 01, 12 bits for 1x
// - conversion takes sample window plus resolution plus two converter clocks
// - one successive-approximation decision per converter clock period
// - writing one to start begins a conversion of the selected input
// - done flag is low while converting and high when finished
// - interrupt on done rising edge when enabled and global enable set
// - high reference is external pin, or supply, 4 V, 3 V, 2 V
// - input chosen only with gate set; eleven pins, quarter supply, else none
// - pin becomes pure analog when its config bit or config reg bit set
// - result is up to twelve bits wide
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
`define SAC_RES_W        12
`define SAC_DIV_W        4
`define SAC_EXTRA_CLKS   5'h02
`define SAC_CH_QUARTER   4'hB
`define SAC_NUM_PINS     11
`define SAC_REF_SUPPLY   2'h3
`define SAC_REF_4V       2'h2
`define SAC_REF_3V       2'h1
`define SAC_REF_2V       2'h0
`endif

// File: pkg/sac_pkg.sv
// types of the converter control block
package sac_pkg;
    typedef enum logic [2:0] {
        SAC_IDLE   = 3'b001,
        SAC_SAMPLE = 3'b010,
        SAC_CONV   = 3'b100
    } sac_state_type;

    typedef enum logic [2:0] {
        SAC_SEL_NONE = 3'b000,
        SAC_SEL_PIN  = 3'b001,
        SAC_SEL_QUAR = 3'b010
    } sac_src_type;

    typedef enum logic [2:0] {
        SAC_RSRC_EXT = 3'b000,
        SAC_RSRC_VDD = 3'b001,
        SAC_RSRC_4V  = 3'b010,
        SAC_RSRC_3V  = 3'b011,
        SAC_RSRC_2V  = 3'b100
    } sac_ref_type;
endpackage : sac_pkg

// File: src/sac_clkdiv.sv
// converter clock tick generator from the cpu clock
`timescale 1ns/10ps
`include "sac_regs.svh"
module sac_clkdiv
    import sac_pkg::*;
(
    input  wire logic       ref_clk,      // cpu clock
    input  wire logic       rstn,         // async reset, active low
    input  wire logic       run,          // count only while converting
    input  wire logic [1:0] div_sel,      // divider select
    output logic            tick          // one cpu cycle per converter clock
);
    logic [`SAC_DIV_W-1:0] cnt;
    logic [`SAC_DIV_W-1:0] last;

    always_comb begin
        unique case (div_sel)
            2'b00: last = 4'hF;
            2'b01: last = 4'h7;
            2'b10: last = 4'h0;
            2'b11: last = 4'h1;
        endcase
    end

    assign tick = run && (cnt >= last);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 4'h0;
        end else if (!run || tick) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : sac_clkdiv

// File: src/sac_control.sv
// successive-approximation converter control top
`timescale 1ns/10ps
`include "sac_regs.svh"
module sac_control
    import sac_pkg::*;
#(
    parameter int RES_W = `SAC_RES_W
)
(
    input  wire logic              ref_clk,                // cpu clock, 10 MHz
    input  wire logic              rstn,                   // async reset, active low
    input  wire logic              converter_power_enable, // analog bias on
    input  wire logic              start_set,              // firmware writes one to start
    input  wire logic [1:0]        adc_clk_div_sel,        // converter clock divider
    input  wire logic [1:0]        sample_width_sel,       // sampling window select
    input  wire logic [1:0]        resolution_sel,         // result bit number select
    input  wire logic              external_ref_select,    // external high reference
    input  wire logic [1:0]        internal_ref_level,     // internal reference level
    input  wire logic              global_channel_gate,    // allows any input
    input  wire logic [3:0]        channel_select,         // input channel
    input  wire logic [7:0]        pin_analog_config,      // pure analog for pins 0..7
    input  wire logic [6:4]        adc_config_reg,         // pure analog for pins 8..10
    input  wire logic              converter_irq_enable,   // converter interrupt enable
    input  wire logic              global_irq_enable,      // global interrupt enable
    input  wire logic              comparator_out,         // analog comparator decision
    output logic                   start_bit,              // start bit readback
    output logic                   conversion_done,        // end of conversion flag
    output logic                   converter_irq,          // one-cycle interrupt request
    output logic [RES_W-1:0]       result,                 // conversion result
    output logic [RES_W-1:0]       dac_code,               // trial code to analog array
    output logic                   sample_hold,            // sampling switch closed
    output logic [`SAC_NUM_PINS-1:0] pin_connect,          // analog mux pin select
    output logic                   quarter_supply_connect, // quarter supply selected
    output sac_ref_type            high_ref_control,       // chosen high reference
    output logic [`SAC_NUM_PINS-1:0] pin_digital_disable   // digital path off per pin
);
    // the bit counter and the resolution decode serve a twelve-bit array only
    if (RES_W != 12) begin : g_res_w_check
        $error("sac_control: RES_W must be 12");
    end

    sac_state_type           state;
    logic                    tick;
    logic [3:0]              samp_cnt;
    logic [3:0]              samp_last;
    logic [3:0]              bit_idx;
    logic [3:0]              lsb_idx;
    logic [1:0]              tail_cnt;
    logic                    done_q;

    sac_clkdiv u_div (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .run     (state != SAC_IDLE),
        .div_sel (adc_clk_div_sel),
        .tick    (tick)
    );

    always_comb begin
        unique case (sample_width_sel)
            2'b00: samp_last = 4'h0;
            2'b01: samp_last = 4'h1;
            2'b10: samp_last = 4'h3;
            2'b11: samp_last = 4'h7;
        endcase
    end

    // lowest bit resolved: 8 bits stop at 4, 10 at 2, 12 at 0
    always_comb begin
        if (resolution_sel[1]) lsb_idx = 4'h0;
        else if (resolution_sel[0]) lsb_idx = 4'h2;
        else lsb_idx = 4'h4;
    end

    // start bit set by firmware, cleared when the conversion begins
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            start_bit <= 1'b0;
        end else if (start_set) begin
            start_bit <= 1'b1;
        end else if (state == SAC_IDLE && start_bit && converter_power_enable) begin
            start_bit <= 1'b0;
        end
    end

    // sequence: sample window, bit decisions, two trailing clocks
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= SAC_IDLE;
            samp_cnt <= 4'h0;
            bit_idx  <= 4'h0;
            tail_cnt <= 2'h0;
            dac_code <= '0;
        end else begin
            unique case (state)
                SAC_IDLE: begin
                    if (start_bit && converter_power_enable) begin
                        state    <= SAC_SAMPLE;
                        samp_cnt <= 4'h0;
                    end
                end
                SAC_SAMPLE: begin
                    if (tick) begin
                        if (samp_cnt == samp_last) begin
                            state    <= SAC_CONV;
                            bit_idx  <= 4'(RES_W - 1);
                            tail_cnt <= 2'h0;
                            dac_code <= {1'b1, {(RES_W-1){1'b0}}};
                        end else begin
                            samp_cnt <= samp_cnt + 4'h1;
                        end
                    end
                end
                SAC_CONV: begin
                    if (tick) begin
                        if (bit_idx != 4'hF) begin
                            // keep or drop the trial bit, try the next one
                            dac_code[bit_idx] <= comparator_out;
                            if (bit_idx == lsb_idx) begin
                                bit_idx <= 4'hF;
                            end else begin
                                dac_code[bit_idx - 4'h1] <= 1'b1;
                                bit_idx <= bit_idx - 4'h1;
                            end
                        end else if (tail_cnt == 2'(`SAC_EXTRA_CLKS - 5'h01)) begin
                            state <= SAC_IDLE;
                        end else begin
                            tail_cnt <= tail_cnt + 2'h1;
                        end
                    end
                end
                default: state <= SAC_IDLE;
            endcase
        end
    end

    assign sample_hold = (state == SAC_SAMPLE);

    // done flag and result
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            conversion_done <= 1'b1;
            result          <= '0;
        end else if (state == SAC_IDLE && start_bit && converter_power_enable) begin
            conversion_done <= 1'b0;
        end else if (state == SAC_CONV && tick && bit_idx == 4'hF
                     && tail_cnt == 2'(`SAC_EXTRA_CLKS - 5'h01)) begin
            conversion_done <= 1'b1;
            result          <= dac_code;
        end
    end

    // interrupt on low-to-high of the done flag
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            done_q        <= 1'b1;
            converter_irq <= 1'b0;
        end else begin
            done_q        <= conversion_done;
            converter_irq <= conversion_done && !done_q
                             && converter_irq_enable && global_irq_enable;
        end
    end

    // reference and input selection
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            high_ref_control       <= SAC_RSRC_2V;
            pin_connect            <= '0;
            quarter_supply_connect <= 1'b0;
            pin_digital_disable    <= '0;
        end else begin
            if (external_ref_select) high_ref_control <= SAC_RSRC_EXT;
            else begin
                unique case (internal_ref_level)
                    `SAC_REF_SUPPLY: high_ref_control <= SAC_RSRC_VDD;
                    `SAC_REF_4V:     high_ref_control <= SAC_RSRC_4V;
                    `SAC_REF_3V:     high_ref_control <= SAC_RSRC_3V;
                    `SAC_REF_2V:     high_ref_control <= SAC_RSRC_2V;
                endcase
            end
            pin_connect <= '0;
            if (global_channel_gate && channel_select < `SAC_CH_QUARTER)
                pin_connect[channel_select] <= 1'b1;
            quarter_supply_connect <= global_channel_gate
                                      && channel_select == `SAC_CH_QUARTER;
            pin_digital_disable <= {adc_config_reg, pin_analog_config};
        end
    end
endmodule : sac_control

// File: bench/sac_control_assertions.sv
// concurrent checks on the ports of the converter control top
`timescale 1ns/10ps
module sac_control_assertions
    import sac_pkg::*;
#(
    parameter int RES_W = 12
)
(
    input wire logic             ref_clk,                // cpu clock
    input wire logic             rstn,                   // async reset
    input wire logic             converter_power_enable, // bias on
    input wire logic             start_set,              // start write
    input wire logic             external_ref_select,    // ext reference
    input wire logic [1:0]       internal_ref_level,     // int level
    input wire logic             global_channel_gate,    // input gate
    input wire logic [3:0]       channel_select,         // channel
    input wire logic [7:0]       pin_analog_config,      // analog pins low
    input wire logic [6:4]       adc_config_reg,         // analog pins high
    input wire logic             converter_irq_enable,   // irq enable
    input wire logic             global_irq_enable,      // global enable
    input wire logic             start_bit,              // start readback
    input wire logic             conversion_done,        // done flag
    input wire logic             converter_irq,          // irq pulse
    input wire logic [RES_W-1:0] result,                 // result
    input wire logic [10:0]      pin_connect,            // pin select
    input wire logic             quarter_supply_connect, // quarter supply
    input wire sac_ref_type      high_ref_control,       // reference
    input wire logic [10:0]      pin_digital_disable     // digital off
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    start_take_a: assert property (start_bit && conversion_done && converter_power_enable && !start_set
        |=> !start_bit && !conversion_done) else $error("start not taken");
    start_hold_a: assert property (start_set && !conversion_done |=> start_bit)
        else $error("start request lost while busy");
    irq_rise_a: assert property ($rose(conversion_done) && converter_irq_enable && global_irq_enable
        |-> ##1 converter_irq) else $error("interrupt missing");
    irq_pulse_a: assert property (converter_irq |-> $past(conversion_done) && !$past(conversion_done, 2)
        ##1 !converter_irq)
        else $error("interrupt not a single pulse after done");
    result_hold_a: assert property (conversion_done && $past(conversion_done) && $past(conversion_done, 2)
        |-> $stable(result)) else $error("result changed while idle");
    pin_dis_a: assert property (1'b1 |=> pin_digital_disable == $past({adc_config_reg, pin_analog_config}))
        else $error("digital disable mismatch");
    ref_sel_a: assert property (1'b1 |=> high_ref_control == ($past(external_ref_select) ? SAC_RSRC_EXT :
        sac_ref_type'(3'h4 - {1'b0, $past(internal_ref_level)}))) else $error("reference mismatch");
    chan_sel_a: assert property (1'b1 |=> pin_connect == ($past(global_channel_gate)
        && $past(channel_select) < 4'hB ? 11'h001 << $past(channel_select) : 11'h000)
        && quarter_supply_connect == ($past(global_channel_gate) && $past(channel_select) == 4'hB))
        else $error("input select mismatch");

    irq_c: cover property (converter_irq);
    take_c: cover property (start_bit && conversion_done ##1 !conversion_done);
    quarter_c: cover property (quarter_supply_connect);
endmodule : sac_control_assertions

bind sac_control sac_control_assertions #(.RES_W(RES_W)) chk_u (.ref_clk, .rstn, .converter_power_enable,
    .start_set, .external_ref_select, .internal_ref_level, .global_channel_gate, .channel_select,
    .pin_analog_config, .adc_config_reg, .converter_irq_enable, .global_irq_enable, .start_bit,
    .conversion_done, .converter_irq, .result, .pin_connect, .quarter_supply_connect, .high_ref_control,
    .pin_digital_disable);

// File: bench/sar_adc_control_test.sv
// self-checking bench for the converter control top
`timescale 1ns/10ps
module sar_adc_control_test;
    import sac_pkg::*;
    logic        ref_clk = 1'b0, rstn, converter_power_enable, start_set, external_ref_select;
    logic        global_channel_gate, converter_irq_enable, global_irq_enable, comparator_out;
    logic [1:0]  adc_clk_div_sel, sample_width_sel, resolution_sel, internal_ref_level;
    logic [3:0]  channel_select;
    logic [7:0]  pin_analog_config;
    logic [6:4]  adc_config_reg;
    logic        start_bit, conversion_done, converter_irq, sample_hold, quarter_supply_connect;
    logic [11:0] result, dac_code, vin;
    logic [10:0] pin_connect, pin_digital_disable;
    sac_ref_type high_ref_control;
    int          seed = 32'hc9c40f41;
    int          num_errors = 0, cmp_count = 0, cycles = 0, busy = 0, irq_seen = 0, irq_exp = 0, smp = 0;
    logic        prev_done = 1'b1;
    logic [11:0] q_res[$];
    int          q_lo[$], q_hi[$], q_smp[$];

    sac_control dut_u (.*);

    always #50 ref_clk = ~ref_clk;

    // analog side: keep the trial bit while the trial code is not above the input
    always @(negedge ref_clk) comparator_out <= (dac_code <= vin);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    // cycle ceiling: settling wait plus all conversions need well under 6000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    always @(posedge ref_clk) begin
        if (converter_irq === 1'b1) irq_seen++;
        if (conversion_done === 1'b0) busy++;
        if (sample_hold === 1'b1) smp++;
        if (conversion_done === 1'b1 && prev_done === 1'b0 && q_res.size() > 0) begin
            check(result, q_res.pop_front());
            check(busy >= q_lo[0] && busy <= q_hi[0], 1);
            check(smp, q_smp.pop_front());
            smp = 0;
            q_lo.delete(0);
            q_hi.delete(0);
            busy = 0;
        end
        prev_done = conversion_done;
    end

    task automatic convert(input logic [3:0] k, input bit twice);
        logic [31:0] r;
        logic [10:0] cfg;
        int d, t;
        @(negedge ref_clk);
        // probe: a start written while the bias is off has to wait for it
        if (k == 4'h8) converter_power_enable = 1'b0;
        r = $random(seed);
        vin = r[11:0];
        r = $random(seed);
        {adc_clk_div_sel, sample_width_sel} = k;
        resolution_sel = r[1:0];
        {external_ref_select, internal_ref_level, global_channel_gate, channel_select} = r[9:2];
        cfg = r[20:10];
        // the converted pin is always made pure analog; its direction and pulls sit outside this block
        if (channel_select < 4'hB) cfg[channel_select] = 1'b1;
        {adc_config_reg, pin_analog_config} = cfg;
        {converter_irq_enable, global_irq_enable} = r[22:21];
        start_set = 1'b1;
        d = adc_clk_div_sel == 2'h0 ? 16 : adc_clk_div_sel == 2'h1 ? 8 : adc_clk_div_sel == 2'h2 ? 1 : 2;
        t = ((1 << sample_width_sel) + (resolution_sel[1] ? 12 : resolution_sel[0] ? 10 : 8) + 2) * d;
        repeat (twice ? 2 : 1) begin
            q_res.push_back(vin & (resolution_sel[1] ? 12'hFFF : resolution_sel[0] ? 12'hFFC : 12'hFF0));
            q_lo.push_back(t - 1);
            q_hi.push_back(t + d + 2);
            q_smp.push_back((1 << sample_width_sel) * d);
            irq_exp += converter_irq_enable & global_irq_enable;
        end
        @(negedge ref_clk);
        start_set = 1'b0;
        if (!converter_power_enable) begin
            repeat (20) @(negedge ref_clk);
            check(conversion_done, 1);
            check(start_bit, 1);
            converter_power_enable = 1'b1;
        end
        if (twice) begin
            repeat (4) @(negedge ref_clk);
            start_set = 1'b1; // second request while busy waits in the start bit
            @(negedge ref_clk);
            start_set = 1'b0;
        end
        repeat (twice ? 2 : 1) begin
            @(negedge ref_clk iff conversion_done === 1'b0);
            @(negedge ref_clk iff conversion_done === 1'b1);
        end
        repeat (4) @(negedge ref_clk);
    endtask : convert

    initial begin
        {rstn, start_set, converter_power_enable, vin} = '0;
        {external_ref_select, internal_ref_level, global_channel_gate, channel_select} = '0;
        {pin_analog_config, adc_config_reg, converter_irq_enable, global_irq_enable} = '0;
        {adc_clk_div_sel, sample_width_sel, resolution_sel} = '0;
        repeat (4) @(negedge ref_clk);
        rstn = 1'b1;
        converter_power_enable = 1'b1;
        repeat (2560) @(negedge ref_clk); // bias settling, 256 us at 100 ns per cycle
        for (int k = 0; k < 16; k++) begin
            convert(k[3:0], k == 5 || k == 12);
        end
        check(irq_seen, irq_exp);
        give_verdict();
    end
endmodule : sar_adc_control_test
